/* hw/scan_pkg.sv */
/*
 Constants, types and the command decoder for the debug scan register set.
 Assumes one system clock of 200 MHz and a Wishbone classic register bus.
*/
package scan_pkg;
   // Register map, byte addresses
   localparam logic [31:0] IR_ADDR = 32'h04000200;
   localparam logic [31:0] STAT_ADDR = 32'h04000204;
   localparam logic [31:0] MASK_ADDR = 32'h04000208;
   // Instruction register layout
   localparam int IR_W = 16;
   localparam logic [15:0] IR_RESET = 16'hffff;
   localparam logic [11:0] IR_LOW_ONES = 12'hfff;
   localparam int IR_CMD_HI = 15;
   localparam int IR_CMD_LO = 12;
   // Pin chain: cell 338 at the data-input end, cell 1 at the data-output end
   localparam int CHAIN_LEN = 338;
   localparam int CELL_DIN_FIRST = 338;
   localparam int CELL_DIN_LAST = 299;
   localparam int CELL_OE_FIRST = 266;
   // Event bits of status and mask
   localparam int EV_W = 4;
   localparam int EV_IRQ = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_RST_ON = 2;
   localparam int EV_RST_OFF = 3;
   // Instruction codes
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_WAKE = 4'h1;
   localparam logic [3:0] OP_SAMPLE = 4'h4;
   localparam logic [3:0] OP_RST_OFF = 4'h6;
   localparam logic [3:0] OP_RST_ON = 4'h7;
   localparam logic [2:0] OP_IRQ_HI = 3'h5;
   localparam logic [3:0] OP_BYPASS = 4'hf;

   typedef enum {
      CMD_EXTEST, CMD_SAMPLE, CMD_RST_OFF, CMD_RST_ON, CMD_IRQ, CMD_WAKE,
      CMD_BYPASS, CMD_RESERVED
   } cmd_t;

   typedef enum {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_t;

   // Scan port pins as seen by the block
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } scan_pins_t;

   // Decodes the 4-bit instruction field
   function automatic cmd_t decode_cmd(input logic [3:0] op);
      cmd_t c;
      c = CMD_RESERVED;
      if (op == OP_EXTEST) c = CMD_EXTEST;
      else if (op == OP_SAMPLE) c = CMD_SAMPLE;
      else if (op == OP_RST_OFF) c = CMD_RST_OFF;
      else if (op == OP_RST_ON) c = CMD_RST_ON;
      else if (op[3:1] == OP_IRQ_HI) c = CMD_IRQ;
      else if (op == OP_WAKE) c = CMD_WAKE;
      else if (op == OP_BYPASS) c = CMD_BYPASS;
      return c;
   endfunction
endpackage

/* hw/scan_regs.sv */
/*
 Debug scan port register set: bypass cell, instruction register with its
 decoder, pin scan chain, the test state machine and a Wishbone slave.
 Assumes scan pins and pad observations arrive asynchronously and are
 oversampled by clk_i; the scan clock must be well below clk_i / 4.
*/
`timescale 1ns/100ps
module scan_regs
   import scan_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Scan port pins
   input wire scan_pkg::scan_pins_t pins_i,
   output logic tdo_o,
   // Pad cells
   input wire logic [scan_pkg::CHAIN_LEN-1:0] pad_obs_i,
   output logic [scan_pkg::CHAIN_LEN-1:0] pad_ctl_o,
   output logic extest_o,
   // Debug actions
   output logic dbg_reset_o,
   output logic dbg_irq_o,
   output logic wake_o,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Interrupt
   output logic irq_o
);
   import scan_pkg::*;

   scan_pins_t s1_q, s2_q;
   logic tck_prev_q;
   logic [CHAIN_LEN-1:0] obs1_q, obs2_q;
   tap_t tap_q, tap_d;
   logic [IR_W-1:0] ir_q, ir_sh_q;
   logic bypass_q;
   logic [CHAIN_LEN-1:0] chain_q, upd_q;
   logic tdo_q, extest_q, dbg_reset_q, dbg_irq_q, wake_q;
   logic [EV_W-1:0] stat_q, mask_q, ev;
   logic [31:0] dat_q;
   logic ack_q, irq_q;
   logic tck_rise, tck_fall, trst_low, bsr_sel, wb_req, stat_rd;
   cmd_t cmd, new_cmd;

   // Two-stage synchronisers for pins and pads
   always_ff @(posedge clk_i) begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      tck_prev_q <= s2_q.tck;
      obs1_q <= pad_obs_i;
      obs2_q <= obs1_q;
   end

   assign tck_rise = s2_q.tck & ~tck_prev_q;
   assign tck_fall = ~s2_q.tck & tck_prev_q;
   assign trst_low = ~s2_q.trst_n;
   assign cmd = decode_cmd(ir_q[IR_CMD_HI:IR_CMD_LO]);
   assign new_cmd = decode_cmd(ir_sh_q[IR_CMD_HI:IR_CMD_LO]);
   assign bsr_sel = (cmd == CMD_EXTEST) || (cmd == CMD_SAMPLE);

   // Test state machine next state, stepped by tms on scan clock rise
   always_comb begin
      tap_d = tap_q;
      case (tap_q)
         TLR: tap_d = s2_q.tms ? TLR : RTI;
         RTI: tap_d = s2_q.tms ? SEL_DR : RTI;
         SEL_DR: tap_d = s2_q.tms ? SEL_IR : CAP_DR;
         CAP_DR: tap_d = s2_q.tms ? EX1_DR : SH_DR;
         SH_DR: tap_d = s2_q.tms ? EX1_DR : SH_DR;
         EX1_DR: tap_d = s2_q.tms ? UPD_DR : PA_DR;
         PA_DR: tap_d = s2_q.tms ? EX2_DR : PA_DR;
         EX2_DR: tap_d = s2_q.tms ? UPD_DR : SH_DR;
         UPD_DR: tap_d = s2_q.tms ? SEL_DR : RTI;
         SEL_IR: tap_d = s2_q.tms ? TLR : CAP_IR;
         CAP_IR: tap_d = s2_q.tms ? EX1_IR : SH_IR;
         SH_IR: tap_d = s2_q.tms ? EX1_IR : SH_IR;
         EX1_IR: tap_d = s2_q.tms ? UPD_IR : PA_IR;
         PA_IR: tap_d = s2_q.tms ? EX2_IR : PA_IR;
         EX2_IR: tap_d = s2_q.tms ? UPD_IR : SH_IR;
         UPD_IR: tap_d = s2_q.tms ? SEL_DR : RTI;
         default: tap_d = TLR;
      endcase
   end

   // State register; test reset forces it without a scan clock edge
   always_ff @(posedge clk_i) begin
      if (rst_i || trst_low) begin
         tap_q <= TLR;
      end else if (tck_rise) begin
         tap_q <= tap_d;
      end
   end

   // Instruction shift path and instruction register
   always_ff @(posedge clk_i) begin
      if (rst_i || trst_low || tap_q == TLR) begin
         ir_q <= IR_RESET;
         ir_sh_q <= IR_RESET;
      end else if (tck_rise) begin
         if (tap_q == CAP_IR) begin
            ir_sh_q <= ir_q;
         end else if (tap_q == SH_IR) begin
            ir_sh_q <= {s2_q.tdi, ir_sh_q[IR_W-1:1]};
         end else if (tap_q == UPD_IR) begin
            ir_q <= {ir_sh_q[IR_CMD_HI:IR_CMD_LO], IR_LOW_ONES};
         end
      end
   end

   // Bypass cell and pin chain; left uninitialised by reset
   always_ff @(posedge clk_i) begin
      if (tck_rise) begin
         if (tap_q == CAP_DR) begin
            bypass_q <= 1'b0;
            if (bsr_sel) begin
               chain_q <= obs2_q;
            end
         end else if (tap_q == SH_DR) begin
            if (bsr_sel) begin
               chain_q <= {s2_q.tdi, chain_q[CHAIN_LEN-1:1]};
            end else begin
               bypass_q <= s2_q.tdi;
            end
         end else if (tap_q == UPD_DR && bsr_sel) begin
            upd_q <= chain_q;
         end
      end
   end

   // Serial output changes on the scan clock fall
   always_ff @(posedge clk_i) begin
      if (rst_i || trst_low) begin
         tdo_q <= 1'b0;
      end else if (tck_fall) begin
         if (tap_q == SH_IR) begin
            tdo_q <= ir_sh_q[0];
         end else if (tap_q == SH_DR) begin
            tdo_q <= bsr_sel ? chain_q[0] : bypass_q;
         end
      end
   end

   // Debug actions from the decoded instruction at update-IR
   always_ff @(posedge clk_i) begin
      if (rst_i || trst_low) begin
         dbg_reset_q <= 1'b0;
         dbg_irq_q <= 1'b0;
         wake_q <= 1'b0;
         extest_q <= 1'b0;
      end else begin
         dbg_irq_q <= tck_rise && tap_q == UPD_IR && new_cmd == CMD_IRQ;
         wake_q <= tck_rise && tap_q == UPD_IR && new_cmd == CMD_WAKE;
         if (tck_rise && tap_q == UPD_IR && new_cmd == CMD_RST_ON) begin
            dbg_reset_q <= 1'b1;
         end else if (tck_rise && tap_q == UPD_IR && new_cmd == CMD_RST_OFF) begin
            dbg_reset_q <= 1'b0;
         end
         extest_q <= (cmd == CMD_EXTEST);
      end
   end

   // Event flags: set wins over the clear by reading status
   assign ev = {dbg_reset_q == 1'b0 && tck_rise && tap_q == UPD_IR && new_cmd == CMD_RST_OFF,
      tck_rise && tap_q == UPD_IR && new_cmd == CMD_RST_ON,
      tck_rise && tap_q == UPD_IR && new_cmd == CMD_WAKE,
      tck_rise && tap_q == UPD_IR && new_cmd == CMD_IRQ};
   assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign stat_rd = wb_req & ~wb_we_i & (wb_adr_i == STAT_ADDR);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~(stat_rd ? stat_q : '0)) | ev;
      end
   end

   // Wishbone slave: one registered ack per request, a cycle after the strobe; CPU writes never reach ir_q
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= '0;
         mask_q <= '0;
      end else begin
         ack_q <= wb_req;
         if (wb_req && wb_we_i && wb_adr_i == MASK_ADDR && wb_sel_i[0]) begin
            mask_q <= wb_dat_i[EV_W-1:0];
         end
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i == IR_ADDR) dat_q <= {16'h0000, ir_q};
            else if (wb_adr_i == STAT_ADDR) dat_q <= {28'h0000000, stat_q};
            else if (wb_adr_i == MASK_ADDR) dat_q <= {28'h0000000, mask_q};
            else dat_q <= '0;
         end
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge clk_i) begin
      if (rst_i) irq_q <= 1'b0;
      else irq_q <= |(stat_q & mask_q);
   end

   assign tdo_o = tdo_q;
   assign pad_ctl_o = upd_q;
   assign extest_o = extest_q;
   assign dbg_reset_o = dbg_reset_q;
   assign dbg_irq_o = dbg_irq_q;
   assign wake_o = wake_q;
   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign irq_o = irq_q;

   a_ir_trst_init: assert property (@(posedge clk_i) trst_low |=> ir_q == IR_RESET)
      else $error("ir not ones after test reset");
   a_ir_low_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      ir_q[11:0] == IR_LOW_ONES)
      else $error("ir low bits not ones");
   a_ir_only_upd: assert property (@(posedge clk_i) disable iff (rst_i || trst_low)
      !(tck_rise && (tap_q == UPD_IR || tap_q == TLR)) && tap_q != TLR |=> $stable(ir_q))
      else $error("ir changed outside update");
   a_ir_upd_load: assert property (@(posedge clk_i) disable iff (rst_i || trst_low)
      tck_rise && tap_q == UPD_IR |=> ir_q[15:12] == $past(ir_sh_q[15:12]))
      else $error("ir update lost");
   a_bypass_tdo: assert property (@(posedge clk_i) disable iff (rst_i || trst_low)
      tck_fall && tap_q == SH_DR && !bsr_sel |=> tdo_q == $past(bypass_q))
      else $error("bypass not on tdo");
   a_chain_tdo: assert property (@(posedge clk_i) disable iff (rst_i || trst_low)
      tck_fall && tap_q == SH_DR && bsr_sel |=> tdo_q == $past(chain_q[0]))
      else $error("chain not on tdo");
   a_ir_read: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_req && !wb_we_i && wb_adr_i == IR_ADDR && $stable(ir_q) |=> wb_ack_o
      && wb_dat_o == {16'h0000, ir_q})
      else $error("ir read wrong");
   a_dbg_rst_on: assert property (@(posedge clk_i) disable iff (rst_i || trst_low)
      tck_rise && tap_q == UPD_IR && new_cmd == CMD_RST_ON |=> ##1 dbg_reset_o)
      else $error("debug reset not asserted");
   a_irq_pulse: assert property (@(posedge clk_i) disable iff (rst_i || trst_low)
      dbg_irq_o |=> !dbg_irq_o)
      else $error("debug interrupt not a pulse");
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule

/* tb/scan_tester.sv */
/*
 External scan tester model: drives the scan pins, 80 ns per scan clock.
 Assumes clk_i at 5 ns; the scan clock rests low between frames.
*/
`timescale 1ns/100ps
module scan_tester (
   // Clock
   input wire logic clk_i,
   // Scan pins
   output scan_pkg::scan_pins_t pins_o,
   input wire logic tdo_i
);
   import scan_pkg::*;
   // Idle pins, data line pulled up
   initial pins_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
   // One scan clock, tdo sampled at its rising edge
   task automatic tick(input logic ms, input logic di, output logic dq);
      pins_o.tms <= ms;
      pins_o.tdi <= di;
      repeat (8) @(posedge clk_i);
      pins_o.tck <= 1'b1;
      dq = tdo_i;
      repeat (8) @(posedge clk_i);
      pins_o.tck <= 1'b0;
   endtask
   // Full IR or DR frame from run-test-idle, LSB first
   task automatic scan(input logic ir, input int n, input logic [337:0] din,
      output logic [337:0] dout);
      logic b;
      dout = '1;
      tick(1'b0, 1'b1, b);
      tick(1'b1, 1'b1, b);
      if (ir) tick(1'b1, 1'b1, b);
      tick(1'b0, 1'b1, b);
      tick(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
      tick(1'b1, 1'b1, b);
      tick(1'b0, 1'b1, b);
   endtask
   // Test reset pin pulse, no scan clock
   task automatic test_reset();
      pins_o.trst_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      pins_o.trst_n <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask
   // Five clocks with mode select high reach test-logic-reset
   task automatic to_tlr();
      logic b;
      repeat (5) tick(1'b1, 1'b1, b);
   endtask
endmodule

/* tb/test_scan_regs.sv */
/*
 Testbench for the scan register set: Wishbone tasks plus scan frames.
 Assumes the tester model drives the scan pins; sync reset for 16 clocks.
*/
`timescale 1ns/100ps
module test_scan_regs;
   import scan_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   scan_pins_t pins;
   logic tdo, extest, dbg_rst, dbg_irq, wake, ack, irq, cyc = 0, stb = 0, we = 0;
   logic [31:0] adr = '0, wdat = '0, rdat, r;
   logic [337:0] obs = {2'b01, {42{8'h3a}}}, ctl, dv;
   logic [337:0] pat = {2'b10, {42{8'hc5}}};
   logic [15:0] prev = 16'hffff;
   // Only defined codes are loaded, with their status events
   logic [3:0] ops [7] = '{4'h6, 4'h1, 4'hb, 4'h7, 4'h4, 4'h0, 4'hf};
   logic [3:0] evs [7] = '{4'h8, 4'h2, 4'h1, 4'h4, 4'h0, 4'h0, 4'h0};
   int err_count = 0;
   int num_checks = 0;
   int irq_pulses = 0;
   int wake_pulses = 0;
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   // Count one-cycle action pulses so each can be compared later
   always @(posedge clk_i) begin
      if (dbg_irq === 1'b1) irq_pulses++;
      if (wake === 1'b1) wake_pulses++;
   end
   scan_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins), .tdo_o(tdo),
      .pad_obs_i(obs), .pad_ctl_o(ctl), .extest_o(extest), .dbg_reset_o(dbg_rst),
      .dbg_irq_o(dbg_irq), .wake_o(wake), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
   scan_tester i_tester (.clk_i(clk_i), .pins_o(pins), .tdo_i(tdo));
   // Verdict and end of run
   task automatic final_report();
      if (err_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Word and flag compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Chain vector compare
   task automatic chkv(input logic [337:0] got, input logic [337:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic Wishbone single cycle, bounded wait for ack
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         final_report();
      end
      q = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask
   // Load an instruction through the scan port
   task automatic load(input logic [3:0] op);
      i_tester.scan(1'b1, 16, {322'h0, op, 12'h000}, dv);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, IR_ADDR, 32'h0, r);
      chk(r, 32'h0000ffff);
      wb(1'b1, IR_ADDR, 32'h0, r);
      wb(1'b0, IR_ADDR, 32'h0, r);
      chk(r, 32'h0000ffff);
      wb(1'b0, 32'h04000210, 32'h0, r);
      chk(r, 32'h0);
      for (int k = 0; k < 7; k++) begin
         load(ops[k]);
         chk(dv[15:0], prev);
         wb(1'b0, IR_ADDR, 32'h0, r);
         chk(r, {16'h0, ops[k], 12'hfff});
         chk(extest, ops[k] == OP_EXTEST);
         chk(dbg_rst, k >= 3);
         chk(irq, 1'b0);
         wb(1'b0, STAT_ADDR, 32'h0, r);
         chk(r, {28'h0, evs[k]});
         prev = {ops[k], 12'hfff};
      end
      chk(irq_pulses, 32'h1);
      chk(wake_pulses, 32'h1);
      i_tester.scan(1'b0, 8, 338'ha5, dv);
      chk(dv[7:1], 7'h25);
      load(OP_EXTEST);
      i_tester.scan(1'b0, 338, pat, dv);
      chkv(dv, obs);
      chkv(ctl, pat);
      wb(1'b1, MASK_ADDR, 32'h1, r);
      load(4'ha);
      chk(irq, 1'b1);
      wb(1'b0, STAT_ADDR, 32'h0, r);
      chk(r, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      load(OP_RST_OFF);
      chk(dbg_rst, 1'b0);
      i_tester.test_reset();
      wb(1'b0, IR_ADDR, 32'h0, r);
      chk(r, 32'h0000ffff);
      load(OP_WAKE);
      i_tester.to_tlr();
      wb(1'b0, IR_ADDR, 32'h0, r);
      chk(r, 32'h0000ffff);
      chk(irq_pulses, 32'h2);
      chk(wake_pulses, 32'h2);
      final_report();
   end
endmodule
